// [logic/mes_map.svh]
// register offsets, event bit positions and reset values of the bank
// assumes: included by the event bank design file by bare name
`ifndef MES_MAP_SVH
`define MES_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define MES_OFS_STATUS_SEL      7'h0B
`define MES_OFS_CLEAR_PROTECT   7'h0C
`define MES_OFS_IRQ_SEL         7'h0D
`define MES_OFS_EVENTS          7'h0E
`define MES_OFS_STATUS          7'h0F

// ****************************************************************
// reset values
// ****************************************************************
`define MES_RST_STATUS_SEL      32'h82029805
`define MES_RST_CLEAR_PROTECT   32'h00000000
`define MES_RST_IRQ_SEL         32'h00000000
`define MES_RST_EVENTS          32'h80000000

// ****************************************************************
// event bit positions
// ****************************************************************
`define MES_EV_RIGHT_SWITCH     12
`define MES_EV_NEG_SOFT         13
`define MES_EV_POS_SOFT         14
`define MES_EV_HOME_ERROR       15
`define MES_EV_POS_LATCH        16
`define MES_EV_FULL_STEP        17
`define MES_EV_ENC_MISMATCH     18
`define MES_EV_INDEX            19
`define MES_EV_ENCODER_LATCH_REGISTER        20
`define MES_EV_SER_ENC_ERR      21
`define MES_EV_RESERVED         22
`define MES_EV_SER_CFG_DONE     23
`define MES_EV_SER_FLAGS        24
`define MES_EV_DRV_SENT         25
`define MES_EV_ENC_STILL        26
`define MES_EV_ANGLE_MAX        27
`define MES_EV_CLOSED_LOOP_WITHIN_TOLERANCE_EVENT           28
`define MES_EV_STALL_STOP       29
`define MES_EV_DRV_FLAG         30
`define MES_EV_RESET            31

// ****************************************************************
// live status field positions
// ****************************************************************
`define MES_ST_TARGET           0
`define MES_ST_COMPARE          1
`define MES_ST_VEL_LO           3
`define MES_ST_VEL_HI           4
`define MES_ST_RAMP_LO          5
`define MES_ST_RAMP_HI          6
`define MES_ST_LEFT_SWITCH      7

`endif

// [logic/mes_pkg.sv]
// types shared by the event and status bank
// assumes: mes_map.svh on the include path
package mes_pkg;

    typedef enum logic [1:0] {
        MES_VEL_ZERO = 2'h0,
        MES_VEL_POS  = 2'h1,
        MES_VEL_NEG  = 2'h2
    } mes_vel_state_e;

    typedef enum logic [1:0] {
        MES_RAMP_CONST = 2'h0,
        MES_RAMP_ACCEL = 2'h1,
        MES_RAMP_DECEL = 2'h2
    } mes_ramp_state_e;

    // register access from the serial port front end
    typedef struct packed {
        logic [6:0]  addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } mes_reg_req_s;

    // motion quantities from the ramp and encoder units
    typedef struct packed {
        logic signed [31:0] actual_position;
        logic signed [31:0] target_position;
        logic signed [31:0] compare_position;
        logic signed [31:0] encoder_position;
        logic        [31:0] encoder_dev_limit;
        logic signed [31:0] current_velocity;
        logic signed [31:0] current_acceleration;
        logic signed [31:0] encoder_velocity;
    } mes_motion_s;

    // level conditions; an event fires on their rising edge, except left_limit_switch, which only feeds the status
    typedef struct packed {
        logic       right_limit_switch;
        logic       right_stop_en;
        logic       left_limit_switch;
        logic       negative_soft_limit;
        logic       negative_soft_limit_en;
        logic       positive_soft_limit;
        logic       positive_soft_limit_en;
        logic       home_ref_mismatch;
        logic       home_outside_margin;
        logic       full_step_active;
        logic       index_active;
        logic       angle_at_max;
        logic       within_tolerance;
        logic [3:0] serial_enc_flags;
        logic [7:0] driver_flags;
        logic [7:0] driver_flag_select;
    } mes_levels_s;

    // one-cycle pulses from the other units
    typedef struct packed {
        logic neg_limit_written;
        logic pos_limit_written;
        logic position_latch_written;
        logic homing_done;
        logic encoder_latch_written;
        logic multi_cycle_fail;
        logic serial_reading_mismatch;
        logic serial_config_received;
        logic driver_datagram_sent;
        logic stall_stop;
    } mes_pulses_s;

endpackage

// [logic/mes_rise_detect.sv]
// rising edge detector over a vector of level conditions
// assumes: levels synchronous to clk; reset already synchronised
`timescale 1ns/1ps

module mes_rise_detect #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // conditions and edges
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise
);

    logic [W-1:0] prev_q;

    // ****************************************************************
    // previous level
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;

endmodule

// [logic/mes_event_bank.sv]
// latched event register, live status register and their masks
// assumes: register requests come from the serial port front end,
// one cycle each; all inputs except resetn are synchronous to clk
`timescale 1ns/1ps

`include "mes_map.svh"

module mes_event_bank
    import mes_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // register access
    input  wire mes_reg_req_s reg_req,
    output logic [31:0]       reg_rdata_q,
    output logic              reg_rvalid_q,
    // event sources
    input  wire mes_motion_s  motion,
    input  wire mes_levels_s  levels,
    input  wire mes_pulses_s  pulses,
    // datagram status and interrupt
    output logic [7:0]        spi_status_q,
    output logic              interrupt_output,
    // motion blocking
    output logic              block_positive_q,
    output logic              block_negative_q
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] abs_diff(
        input logic signed [31:0] a,
        input logic signed [31:0] b
    );
        logic signed [32:0] d;
        d = 33'(a) - 33'(b);
        if (d < 0) begin
            d = -d;
        end
        return d[31:0];
    endfunction

    // first eight selected bits, lowest first
    function automatic logic [7:0] pack_selected(
        input logic [31:0] ev,
        input logic [31:0] sel
    );
        logic [7:0] res;
        int         n;
        res = '0;
        n   = 0;
        for (int i = 0; i < 32; i++) begin
            if (sel[i] && n < 8) begin
                res[n[2:0]] = ev[i];
                n = n + 1;
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [31:0] status_sel_q;
    logic [31:0] clear_protect_q;
    logic [31:0] irq_sel_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_sel_q    <= `MES_RST_STATUS_SEL;
            clear_protect_q <= `MES_RST_CLEAR_PROTECT;
            irq_sel_q       <= `MES_RST_IRQ_SEL;
        end else if (reg_req.wr) begin
            if (reg_req.addr == `MES_OFS_STATUS_SEL) begin
                status_sel_q <= reg_req.wdata;
            end
            if (reg_req.addr == `MES_OFS_CLEAR_PROTECT) begin
                clear_protect_q <= reg_req.wdata;
            end
            if (reg_req.addr == `MES_OFS_IRQ_SEL) begin
                irq_sel_q <= reg_req.wdata;
            end
        end
    end

    // ****************************************************************
    // level conditions and edges
    // ****************************************************************
    localparam int NLVL = 19;

    logic [NLVL-1:0] lvl;
    logic [NLVL-1:0] lvl_rise;
    logic            mismatch_cond;
    logic            enc_still_cond;

    assign mismatch_cond  = abs_diff(motion.actual_position,
                                     motion.encoder_position)
                            > motion.encoder_dev_limit;
    assign enc_still_cond = motion.encoder_velocity == 32'sh0;

    assign lvl = {
        levels.driver_flags & levels.driver_flag_select,
        |levels.serial_enc_flags,
        levels.within_tolerance,
        levels.angle_at_max,
        enc_still_cond,
        levels.index_active,
        mismatch_cond,
        levels.full_step_active,
        levels.home_ref_mismatch & levels.home_outside_margin,
        levels.positive_soft_limit & levels.positive_soft_limit_en,
        levels.negative_soft_limit & levels.negative_soft_limit_en,
        levels.right_limit_switch & levels.right_stop_en
    };

    mes_rise_detect #(
        .W(NLVL)
    ) u_rise (
        .clk  (clk),
        .rst_n(rst_n),
        .level(lvl),
        .rise (lvl_rise)
    );

    // ****************************************************************
    // event set vector
    // ****************************************************************
    logic [31:0] ev_set;

    always_comb begin
        ev_set = '0;
        ev_set[`MES_EV_RIGHT_SWITCH] = lvl_rise[0];
        ev_set[`MES_EV_NEG_SOFT]     = lvl_rise[1];
        ev_set[`MES_EV_POS_SOFT]     = lvl_rise[2];
        ev_set[`MES_EV_HOME_ERROR]   = lvl_rise[3];
        ev_set[`MES_EV_POS_LATCH]    = pulses.position_latch_written
                                     | pulses.homing_done;
        ev_set[`MES_EV_FULL_STEP]    = lvl_rise[4];
        ev_set[`MES_EV_ENC_MISMATCH] = lvl_rise[5];
        ev_set[`MES_EV_INDEX]        = lvl_rise[6];
        ev_set[`MES_EV_ENCODER_LATCH_REGISTER]    = pulses.encoder_latch_written;
        ev_set[`MES_EV_SER_ENC_ERR]  = pulses.multi_cycle_fail
                                     | pulses.serial_reading_mismatch;
        ev_set[`MES_EV_SER_CFG_DONE] = pulses.serial_config_received;
        ev_set[`MES_EV_SER_FLAGS]    = lvl_rise[10];
        ev_set[`MES_EV_DRV_SENT]     = pulses.driver_datagram_sent;
        ev_set[`MES_EV_ENC_STILL]    = lvl_rise[7];
        ev_set[`MES_EV_ANGLE_MAX]    = lvl_rise[8];
        ev_set[`MES_EV_CLOSED_LOOP_WITHIN_TOLERANCE_EVENT]       = lvl_rise[9];
        ev_set[`MES_EV_STALL_STOP]   = pulses.stall_stop;
        ev_set[`MES_EV_DRV_FLAG]     = |lvl_rise[18:11];
    end

    // ****************************************************************
    // latched events
    // ****************************************************************
    logic [31:0] events_q;
    logic [31:0] events_d;
    logic        ev_read;

    assign ev_read = reg_req.rd && reg_req.addr == `MES_OFS_EVENTS;

    always_comb begin
        events_d = events_q;
        if (ev_read) begin
            events_d = events_q & clear_protect_q;
        end
        events_d = events_d | ev_set;
        events_d[`MES_EV_RESERVED] = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            events_q <= `MES_RST_EVENTS;
        end else begin
            events_q <= events_d;
        end
    end

    // ****************************************************************
    // live status
    // ****************************************************************
    mes_vel_state_e  vel_state;
    mes_ramp_state_e ramp_state;
    logic [31:0]     status_word;

    always_comb begin
        if (motion.current_velocity == 32'sh0) begin
            vel_state = MES_VEL_ZERO;
        end else if (motion.current_velocity > 32'sh0) begin
            vel_state = MES_VEL_POS;
        end else begin
            vel_state = MES_VEL_NEG;
        end
    end

    always_comb begin
        if (motion.current_acceleration == 32'sh0) begin
            ramp_state = MES_RAMP_CONST;
        end else if ((motion.current_acceleration < 32'sh0)
                     == (motion.current_velocity < 32'sh0)) begin
            ramp_state = MES_RAMP_ACCEL;
        end else begin
            ramp_state = MES_RAMP_DECEL;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[`MES_ST_TARGET] =
            motion.actual_position == motion.target_position;
        status_word[`MES_ST_COMPARE] =
            motion.actual_position == motion.compare_position;
        status_word[`MES_ST_VEL_HI:`MES_ST_VEL_LO] = vel_state;
        status_word[`MES_ST_RAMP_HI:`MES_ST_RAMP_LO] = ramp_state;
        status_word[`MES_ST_LEFT_SWITCH] = levels.left_limit_switch;
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q  <= '0;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_req.rd;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    `MES_OFS_STATUS_SEL:    reg_rdata_q <= status_sel_q;
                    `MES_OFS_CLEAR_PROTECT: reg_rdata_q <= clear_protect_q;
                    `MES_OFS_IRQ_SEL:       reg_rdata_q <= irq_sel_q;
                    `MES_OFS_EVENTS:        reg_rdata_q <= events_q;
                    `MES_OFS_STATUS:        reg_rdata_q <= status_word;
                    default:                reg_rdata_q <= '0;
                endcase
            end
        end
    end

    // ****************************************************************
    // datagram status and interrupt
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_status_q <= '0;
        end else begin
            spi_status_q <= pack_selected(events_d, status_sel_q);
        end
    end

    assign interrupt_output = |(events_q & irq_sel_q);

    // ****************************************************************
    // motion blocking
    // ****************************************************************
    logic right_block_q;
    logic neg_soft_block_q;
    logic pos_soft_block_q;
    logic neg_new_val_q;
    logic pos_new_val_q;
    logic neg_soft_release;
    logic pos_soft_release;

    // release needs event cleared by the host first
    assign neg_soft_release = !events_q[`MES_EV_NEG_SOFT]
                            && (neg_new_val_q
                                || !levels.negative_soft_limit_en);
    assign pos_soft_release = !events_q[`MES_EV_POS_SOFT]
                            && (pos_new_val_q
                                || !levels.positive_soft_limit_en);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            right_block_q <= 1'b0;
        end else if (ev_set[`MES_EV_RIGHT_SWITCH]) begin
            right_block_q <= 1'b1;
        end else if (!events_q[`MES_EV_RIGHT_SWITCH]
                     && (!levels.right_limit_switch
                         || !levels.right_stop_en)) begin
            right_block_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_soft_block_q <= 1'b0;
            neg_new_val_q    <= 1'b0;
        end else if (ev_set[`MES_EV_NEG_SOFT]) begin
            neg_soft_block_q <= 1'b1;
            neg_new_val_q    <= 1'b0;
        end else if (neg_soft_block_q && neg_soft_release) begin
            neg_soft_block_q <= 1'b0;
            neg_new_val_q    <= 1'b0;
        end else if (neg_soft_block_q && pulses.neg_limit_written) begin
            neg_new_val_q    <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_soft_block_q <= 1'b0;
            pos_new_val_q    <= 1'b0;
        end else if (ev_set[`MES_EV_POS_SOFT]) begin
            pos_soft_block_q <= 1'b1;
            pos_new_val_q    <= 1'b0;
        end else if (pos_soft_block_q && pos_soft_release) begin
            pos_soft_block_q <= 1'b0;
            pos_new_val_q    <= 1'b0;
        end else if (pos_soft_block_q && pulses.pos_limit_written) begin
            pos_new_val_q    <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            block_positive_q <= 1'b0;
            block_negative_q <= 1'b0;
        end else begin
            block_positive_q <= right_block_q || pos_soft_block_q;
            block_negative_q <= neg_soft_block_q;
        end
    end

endmodule

// [dv/mes_event_bank_asserts.sv]
// checker for the event and status bank ports
// assumes: bound onto mes_event_bank, reset low while resetn low
`timescale 1ns/1ps
module mes_event_bank_asserts
    import mes_pkg::*;
(
    // watched ports
    input wire logic         clk,
    input wire logic         resetn,
    input wire mes_reg_req_s reg_req,
    input wire logic [31:0]  reg_rdata_q,
    input wire logic         reg_rvalid_q,
    input wire mes_motion_s  motion,
    input wire mes_levels_s  levels,
    input wire mes_pulses_s  pulses,
    input wire logic         block_positive_q,
    input wire logic         block_negative_q
);
    logic [1:0] vel_c;
    logic [1:0] ramp_c;
    logic [1:0] hit_c;
    logic       rd_ev;
    logic       rd_st;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ********************************
    // expected status fields
    // ********************************
    assign rd_ev = reg_req.rd && reg_req.addr == 7'h0E;
    assign rd_st = reg_req.rd && reg_req.addr == 7'h0F;
    assign hit_c = {motion.actual_position == motion.compare_position,
                    motion.actual_position == motion.target_position};
    assign vel_c = motion.current_velocity == 0 ? 2'h0 :
                   motion.current_velocity[31] ? 2'h2 : 2'h1;
    assign ramp_c = motion.current_acceleration == 0 ? 2'h0 :
        (motion.current_acceleration[31] == motion.current_velocity[31])
        ? 2'h1 : 2'h2;
    // ********************************
    // properties
    // ********************************
    read_answer_a: assert property (reg_req.rd |=> reg_rvalid_q)
        else $error("read not answered");
    no_answer_a: assert property (!reg_req.rd |=> !reg_rvalid_q)
        else $error("answer without read");
    pos_flags_a: assert property (
        rd_st |=> reg_rdata_q[1:0] == $past(hit_c))
        else $error("position flags wrong");
    vel_state_a: assert property (
        rd_st |=> reg_rdata_q[4:3] == $past(vel_c))
        else $error("velocity state wrong");
    ramp_state_a: assert property (
        rd_st |=> reg_rdata_q[6:5] == $past(ramp_c))
        else $error("ramp state wrong");
    reserved_bit_a: assert property (rd_ev |=> !reg_rdata_q[22])
        else $error("reserved event bit set");
    stall_event_a: assert property (
        pulses.stall_stop ##[1:2] rd_ev |=> reg_rdata_q[29])
        else $error("stall event missing");
    right_block_a: assert property (
        $rose(levels.right_limit_switch) && levels.right_stop_en
        |-> ##2 block_positive_q)
        else $error("positive motion not blocked");
    soft_block_a: assert property (
        $rose(levels.negative_soft_limit) && levels.negative_soft_limit_en
        |-> ##[1:2] block_negative_q)
        else $error("negative motion not blocked");
endmodule

bind mes_event_bank mes_event_bank_asserts u_chk (
    .clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .motion(motion), .levels(levels), .pulses(pulses),
    .block_positive_q(block_positive_q),
    .block_negative_q(block_negative_q)
);

// [dv/mes_host_model.sv]
// host side model: register reads and writes over the port
// assumes: calls are made after reset release, one at a time
`timescale 1ns/1ps
module mes_host_model
    import mes_pkg::*;
(
    // clock
    input  wire logic   clk,
    // register requests
    output mes_reg_req_s req
);
    initial req = '0;
    // one-cycle read strobe; events read before resume
    task automatic rd(input logic [6:0] a);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'h1;
        @(posedge clk);
        req.rd   <= 1'h0;
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'h1;
        @(posedge clk);
        req.wr    <= 1'h0;
    endtask
endmodule

// [dv/mes_event_bank_tb.sv]
// self-checking bench for the event and status bank
// assumes: host model and bound checker compiled alongside
`timescale 1ns/1ps
module mes_event_bank_tb import mes_pkg::*;;
    logic clk, resetn, rvalid, irq, bp, bn;
    logic [31:0] rdata, x, t, c;
    logic [7:0] sst;
    logic signed [31:0] v, a;
    mes_reg_req_s req;
    mes_motion_s mo;
    mes_levels_s lv, lv0;
    mes_pulses_s pu;
    logic [63:0] expq[$];
    int miscompares = 0, checks_done = 0, cyc = 0;
    int pev[8] = '{29, 25, 23, 21, 21, 20, 16, 16};
    int lev[8] = '{17, 19, 27, 28, 24, 30, 15, 26};
    mes_host_model host (.clk(clk), .req(req));
    mes_event_bank dut (.clk(clk), .resetn(resetn), .reg_req(req),
        .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .motion(mo),
        .levels(lv), .pulses(pu), .spi_status_q(sst),
        .interrupt_output(irq), .block_positive_q(bp),
        .block_negative_q(bn));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // ********************************
    // tasks
    // ********************************
    task automatic cmp_rd(input logic [31:0] got, input logic [63:0] e);
        checks_done++;
        if ((got & e[63:32]) !== e[31:0]) begin
            miscompares++;
            $display("[FAIL] %0t read %h want %h", $time, got, e[31:0]);
        end
    endtask
    task automatic cmp_out(input logic [7:0] got, input logic [7:0] e);
        checks_done++;
        if (got !== e) begin
            miscompares++;
            $display("[FAIL] %0t output %h want %h", $time, got, e);
        end
    endtask
    task automatic rd_x(input logic [6:0] ad, input logic [31:0] m, e);
        expq.push_back({m, e});
        host.rd(ad);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        pu[i] <= 1'h1;
        @(posedge clk);
        pu <= '0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic finish_test();
        if (expq.size() != 0) begin
            miscompares++;
            $display("[FAIL] %0t %0d reads unanswered", $time, expq.size());
        end
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ********************************
    // read monitor and timeout
    // ********************************
    always @(posedge clk) begin
        cyc++;
        if (rvalid === 1'h1) begin
            if (expq.size() > 0) cmp_rd(rdata, expq.pop_front());
            else begin
                miscompares++;
                $display("[FAIL] %0t answer with no read", $time);
            end
        end
        if (cyc == 5000) begin
            miscompares++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    // ********************************
    // scenarios
    // ********************************
    initial begin
        void'($urandom(47789));
        resetn = 1'h0;
        mo = '0;
        mo.encoder_dev_limit = '1;
        mo.encoder_velocity = 32'h1;
        lv0 = '0;
        lv0.right_stop_en = 1'h1;
        lv0.negative_soft_limit_en = 1'h1;
        lv0.positive_soft_limit_en = 1'h1;
        lv0.driver_flag_select = 8'h01;
        lv = lv0;
        pu = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        tick(3);
        cmp_out(sst, 8'h80);
        rd_x(7'h0B, '1, 32'h82029805);
        rd_x(7'h0C, '1, 32'h0);
        rd_x(7'h0D, '1, 32'h0);
        rd_x(7'h0E, '1, 32'h80000000);
        rd_x(7'h0E, '1, 32'h0);
        rd_x(7'h15, '1, 32'h0);
        foreach (pev[i]) begin
            pulse(i);
            rd_x(7'h0E, '1, 32'h1 << pev[i]);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            case (i)
                0: lv.full_step_active <= 1'h1;
                1: lv.index_active <= 1'h1;
                2: lv.angle_at_max <= 1'h1;
                3: lv.within_tolerance <= 1'h1;
                4: lv.serial_enc_flags <= 4'h4;
                5: lv.driver_flags <= 8'h01;
                6: lv[25:24] <= 2'h3;
                default: mo.encoder_velocity <= '0;
            endcase
            rd_x(7'h0E, '1, 32'h1 << lev[i]);
        end
        rd_x(7'h0E, '1, 32'h0);
        @(posedge clk);
        mo.encoder_position <= 32'h5;
        mo.encoder_dev_limit <= 32'h5;
        rd_x(7'h0E, '1, 32'h0);
        mo.encoder_dev_limit <= 32'h4;
        rd_x(7'h0E, '1, 32'h1 << 18);
        lv <= lv0;
        mo.encoder_dev_limit <= '1;
        host.wr(7'h0C, 32'h1 << 25);
        host.wr(7'h0D, 32'h1 << 29);
        pulse(1);
        tick(0);
        cmp_out(sst, 8'h40);
        cmp_out({7'h0, irq}, 8'h0);
        rd_x(7'h0E, '1, 32'h1 << 25);
        rd_x(7'h0E, '1, 32'h1 << 25);
        pulse(0);
        tick(0);
        cmp_out({7'h0, irq}, 8'h1);
        host.wr(7'h0C, 32'h0);
        rd_x(7'h0E, '1, 32'h22000000);
        tick(2);
        cmp_out({7'h0, irq}, 8'h0);
        cmp_out(sst, 8'h00);
        @(posedge clk);
        lv.right_limit_switch <= 1'h1;
        lv.negative_soft_limit <= 1'h1;
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h3);
        @(posedge clk);
        lv.right_limit_switch <= 1'h0;
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h3);
        rd_x(7'h0E, '1, 32'h3000);
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h1);
        pulse(9);
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h0);
        @(posedge clk);
        lv.positive_soft_limit <= 1'h1;
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h2);
        @(posedge clk);
        lv.positive_soft_limit_en <= 1'h0;
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h2);
        rd_x(7'h0E, '1, 32'h1 << 14);
        tick(3);
        cmp_out({6'h0, bp, bn}, 8'h0);
        repeat (12) begin
            v = ($urandom_range(2) == 0) ? 32'h0 : $urandom;
            a = ($urandom_range(2) == 0) ? 32'h0 : $urandom;
            x = $urandom_range(3);
            t = $urandom_range(3);
            c = $urandom_range(3);
            @(posedge clk);
            mo.current_velocity <= v;
            mo.current_acceleration <= a;
            mo.actual_position <= x;
            mo.target_position <= t;
            mo.compare_position <= c;
            rd_x(7'h0F, '1, {25'h0, (a == 0) ? 2'h0 :
                (a[31] == v[31]) ? 2'h1 : 2'h2, (v == 0) ? 2'h0 :
                v[31] ? 2'h2 : 2'h1, 1'h0, x == c, x == t});
        end
        @(posedge clk);
        lv <= lv0;
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        tick(3);
        cmp_out(sst, 8'h80);
        rd_x(7'h0E, '1, 32'h84000000);
        tick(4);
        finish_test();
    end
endmodule
